/* File: logic/smss_pkg.sv */
package smss_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_MAP = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_TXDATA = 8'h0c;
  localparam logic [7:0] A_RXDATA = 8'h10;
  localparam logic [7:0] A_FLUSH = 8'h14;
  localparam logic [7:0] A_CLEAR = 8'h18;
  localparam logic [7:0] A_TGT_BASE = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CF_ENABLE = 0;
  localparam int CF_SLAVE = 1;
  localparam int CF_SEQ = 2;
  localparam int CF_COMMIT = 3;
  localparam int CF_ISD = 8;
  localparam int CA_SIZE = 0;
  localparam int CA_WORDS = 4;
  localparam int CA_GAP = 12;
  localparam int CA_CSPULSE = 20;
  localparam int CB_DIV = 0;
  localparam int CB_GUARD = 8;
  localparam int CB_POL = 16;
  localparam int CB_PHA = 17;
  localparam int ST_TXCNT = 8;
  localparam int ST_RXCNT = 16;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [31:0] CFGA_RST = 32'h0000_0017;
  localparam logic [31:0] CFGB_RST = 32'h0000_0104;
  localparam logic [1:0] MAP_OFF = 2'b00;
  localparam logic [1:0] MAP_ON = 2'b01;
  localparam logic [1:0] MAP_SKIP = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_PRE, ST_SHIFT, ST_POST, ST_GAP, ST_SWITCH
  } smss_state_t;

endpackage

/* File: logic/smss_sync.sv */
`timescale 1ns/100ps
module smss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* File: logic/smss_top.sv */
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module smss_top #(
  parameter int NT = 4,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Serial pins
  output logic SCK_OUT,
  output logic SCK_OE_N,
  input wire logic SCK_IN,
  output logic [NT-1:0] CS_OUT_N,
  input wire logic CS_IN_N,
  output logic TXD,
  output logic TXD_OE_N,
  input wire logic RXD,
  // Sequence completion
  output logic SEQ_READY
);

  localparam int AW = $clog2(DEPTH);
  localparam int TW = (NT > 1) ? $clog2(NT) : 1;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic en;
    logic slave;
    logic seq;
    logic commit;
    logic [7:0] isd;
    logic [NT-1:0][1:0] map;
    logic [NT-1:0][31:0] cfga;
    logic [NT-1:0][31:0] cfgb;
    logic [DEPTH-1:0][15:0] txm;
    logic [DEPTH-1:0][15:0] rxm;
    logic [AW:0] twr;
    logic [AW:0] trd;
    logic [AW:0] tbase;
    logic [AW:0] rwr;
    logic [AW:0] rrd;
    logic seq_ready;
    logic running;
    smss_pkg::smss_state_t st;
    logic [7:0] div;
    logic [9:0] cnt;
    logic [5:0] edges;
    logic [7:0] words;
    logic [TW-1:0] tgt;
    logic mute;
    logic [15:0] tsh;
    logic [15:0] rsh;
    logic sck;
    logic sck_d;
    logic sl_act;
    logic txd;
    logic txd_oe_n;
    logic sck_oe_n;
    logic [NT-1:0] cs;
  } smss_regs_t;

  smss_regs_t s;
  smss_regs_t next_s;

  logic sck_s;
  logic cs_s;
  logic rxd_s;
  logic go_word;
  logic slv_load;
  logic push;
  logic fin;
  logic step;
  logic last;
  logic tick;
  logic tx_empty;
  logic tx_full;
  logic rx_empty;
  logic rx_full;
  logic pick_ok;
  logic ap;
  logic [TW-1:0] pick_t;
  logic [31:0] ca;
  logic [31:0] cb;
  logic [31:0] nca;
  logic [4:0] bits;
  logic [4:0] nbits;
  logic [15:0] mask;
  logic [15:0] push_d;
  logic [7:0] guard;
  logic [7:0] toff;
  logic [7:0] roff;
  int from_idx;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  smss_sync #(.W(3)) u_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({SCK_IN, CS_IN_N, RXD}),
    .q({sck_s, cs_s, rxd_s})
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    go_word = 1'b0;
    slv_load = 1'b0;
    push = 1'b0;
    push_d = 16'h0000;
    fin = 1'b0;
    step = 1'b0;
    last = 1'b0;
    pick_ok = 1'b0;
    pick_t = '0;
    nca = 32'h0000_0000;
    nbits = 5'h00;
    ca = s.cfga[s.tgt];
    cb = s.cfgb[s.tgt];
    bits = {1'b0, ca[smss_pkg::CA_SIZE +: 4]} + 5'h01;
    mask = 16'hffff >> (5'h10 - bits);
    guard = cb[smss_pkg::CB_GUARD +: 8];
    if (guard == 8'h00) begin
      guard = 8'h01;
    end
    tx_empty = (s.twr == s.trd);
    tx_full = ((s.twr - s.tbase) == (AW + 1)'(DEPTH));
    rx_empty = (s.rwr == s.rrd);
    rx_full = ((s.rwr - s.rrd) == (AW + 1)'(DEPTH));
    tick = (s.div == 8'h00);
    next_s.div = tick ? cb[smss_pkg::CB_DIV +: 8] : s.div - 8'h01;
    next_s.sck_d = sck_s;
    next_s.sck_oe_n = s.slave;
    // Lowest usable target at or above the search start
    from_idx = (s.st == smss_pkg::ST_IDLE) ? 0 : int'(s.tgt) + 1;
    for (int i = NT - 1; i >= 0; i--) begin
      if (i >= from_idx && (s.seq ? (s.map[i] != smss_pkg::MAP_OFF &&
          s.cfga[i][smss_pkg::CA_WORDS +: 8] != 8'h00) : s.map[i] == smss_pkg::MAP_ON)) begin
        pick_ok = 1'b1;
        pick_t = TW'(i);
      end
    end

    // ----------------------------------------
    // Master sequencer
    // ----------------------------------------
    if (!s.slave && s.st == smss_pkg::ST_IDLE) begin
      next_s.sck = cb[smss_pkg::CB_POL];
      if (s.en && pick_ok && (s.seq || !tx_empty)) begin
        next_s.tgt = pick_t;
        next_s.running = s.seq;
        next_s.mute = s.seq && s.map[pick_t] == smss_pkg::MAP_SKIP;
        next_s.words = s.cfga[pick_t][smss_pkg::CA_WORDS +: 8];
        if (s.seq) begin
          next_s.trd = s.tbase;
        end
        go_word = 1'b1;
      end
    end else if (!s.slave && !s.running && !s.en) begin
      // Normal transfers drop the word in flight when disabled
      next_s.st = smss_pkg::ST_IDLE;
      next_s.cs = '1;
      next_s.txd = 1'b0;
      next_s.txd_oe_n = 1'b1;
    end else if (!s.slave && tick) begin
      if (s.st inside {smss_pkg::ST_PRE, smss_pkg::ST_POST, smss_pkg::ST_GAP,
          smss_pkg::ST_SWITCH} && s.cnt != 10'h000) begin
        next_s.cnt = s.cnt - 10'h001;
      end else begin
        unique case (s.st)
          smss_pkg::ST_IDLE: begin
          end
          smss_pkg::ST_LEAD: begin
            next_s.txd = s.tsh[15] & ~s.mute;
            next_s.st = smss_pkg::ST_PRE;
            next_s.cnt = {1'b0, guard, 1'b0} - 10'h001;
          end
          smss_pkg::ST_PRE: begin
            next_s.st = smss_pkg::ST_SHIFT;
            next_s.edges = 6'h00;
          end
          smss_pkg::ST_SHIFT: begin
            step = 1'b1;
            next_s.sck = s.sck ^ ~s.mute;
          end
          smss_pkg::ST_POST: begin
            push = 1'b1;
            push_d = s.mute ? 16'h0000 : s.rsh & mask;
            next_s.words = s.words - 8'h01;
            next_s.txd = 1'b0;
            if (s.running ? s.words != 8'h01 : (!tx_empty && s.en)) begin
              if (ca[smss_pkg::CA_GAP +: 8] == 8'h00) begin
                go_word = 1'b1;
              end else begin
                next_s.st = smss_pkg::ST_GAP;
                next_s.cnt = {1'b0, ca[smss_pkg::CA_GAP +: 8], 1'b0} - 10'h001;
                next_s.cs[s.tgt] = s.mute | ca[smss_pkg::CA_CSPULSE];
              end
            end else begin
              next_s.cs = '1;
              next_s.txd_oe_n = 1'b1;
              next_s.st = smss_pkg::ST_IDLE;
              if (s.running && pick_ok) begin
                next_s.tgt = pick_t;
                next_s.mute = s.map[pick_t] == smss_pkg::MAP_SKIP;
                next_s.words = s.cfga[pick_t][smss_pkg::CA_WORDS +: 8];
                if (s.isd == 8'h00) begin
                  go_word = 1'b1;
                end else begin
                  next_s.st = smss_pkg::ST_SWITCH;
                  next_s.cnt = {1'b0, s.isd, 1'b0} - 10'h001;
                end
              end else if (s.running) begin
                fin = 1'b1;
                next_s.running = 1'b0;
                next_s.en = 1'b0;
                next_s.commit = 1'b0;
              end
            end
          end
          smss_pkg::ST_GAP, smss_pkg::ST_SWITCH: begin
            go_word = 1'b1;
          end
        endcase
      end
    end

    // ----------------------------------------
    // Slave engine, always on target 0 settings
    // ----------------------------------------
    if (s.slave) begin
      next_s.tgt = '0;
      next_s.running = 1'b0;
      next_s.cs = '1;
      next_s.sck = cb[smss_pkg::CB_POL];
      if (!s.en || cs_s) begin
        next_s.sl_act = 1'b0;
        next_s.txd = 1'b0;
        next_s.txd_oe_n = 1'b1;
      end else if (!s.sl_act) begin
        next_s.sl_act = 1'b1;
        next_s.txd_oe_n = 1'b0;
        slv_load = 1'b1;
      end else if (sck_s != s.sck_d) begin
        step = 1'b1;
      end
    end

    // ----------------------------------------
    // Shared bit step: even edges lead, odd edges trail
    // ----------------------------------------
    if (step) begin
      next_s.edges = s.edges + 6'h01;
      last = (s.edges == {bits, 1'b0} - 6'h01);
      if (s.edges[0] == cb[smss_pkg::CB_PHA]) begin
        next_s.rsh = {s.rsh[14:0], rxd_s & ~s.mute};
      end else if (s.edges != 6'h00) begin
        next_s.tsh = {s.tsh[14:0], 1'b0};
        next_s.txd = s.tsh[14] & ~s.mute;
      end
      if (last && s.slave) begin
        push = 1'b1;
        push_d = next_s.rsh & mask;
        slv_load = 1'b1;
      end else if (last) begin
        next_s.st = smss_pkg::ST_POST;
        next_s.cnt = {1'b0, guard, 1'b0} - 10'h001;
      end
    end

    if (slv_load) begin
      next_s.edges = 6'h00;
      next_s.tsh = tx_empty ? 16'h0000 : s.txm[s.trd[AW-1:0]] << (5'h10 - bits);
      next_s.txd = tx_empty ? 1'b0 : next_s.tsh[15];
      if (!tx_empty) begin
        next_s.trd = s.trd + (AW + 1)'(1);
      end
    end

    if (go_word) begin
      nca = s.cfga[next_s.tgt];
      nbits = {1'b0, nca[smss_pkg::CA_SIZE +: 4]} + 5'h01;
      next_s.tsh = s.txm[next_s.trd[AW-1:0]] << (5'h10 - nbits);
      next_s.trd = next_s.trd + (AW + 1)'(1);
      next_s.st = smss_pkg::ST_LEAD;
      next_s.div = s.cfgb[next_s.tgt][smss_pkg::CB_DIV +: 8];
      next_s.sck = s.cfgb[next_s.tgt][smss_pkg::CB_POL];
      if (!next_s.mute) begin
        next_s.cs[next_s.tgt] = 1'b0;
        next_s.txd_oe_n = 1'b0;
      end
    end

    if (push && !rx_full) begin
      next_s.rxm[s.rwr[AW-1:0]] = push_d;
      next_s.rwr = s.rwr + (AW + 1)'(1);
    end

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    ap = HSEL && HTRANS[1] && HREADY;
    next_s.dp_wr = ap && HWRITE;
    next_s.dp_addr = HADDR[7:0];
    next_s.hrdata = 32'h0000_0000;
    roff = HADDR[7:0] - smss_pkg::A_TGT_BASE;
    if (ap && !HWRITE) begin
      if (HADDR[7:0] == smss_pkg::A_CONFIG) begin
        next_s.hrdata = {16'h0000, s.isd, 4'h0, s.commit, s.seq, s.slave, s.en};
      end else if (HADDR[7:0] == smss_pkg::A_MAP) begin
        next_s.hrdata[2*NT-1:0] = s.map;
      end else if (HADDR[7:0] == smss_pkg::A_STATUS) begin
        next_s.hrdata[0] = s.seq_ready;
        next_s.hrdata[1] = s.running;
        next_s.hrdata[2] = (s.st != smss_pkg::ST_IDLE) || s.sl_act;
        next_s.hrdata[smss_pkg::ST_TXCNT +: AW + 1] = s.twr - s.trd;
        next_s.hrdata[smss_pkg::ST_RXCNT +: AW + 1] = s.rwr - s.rrd;
      end else if (HADDR[7:0] == smss_pkg::A_RXDATA && !rx_empty) begin
        next_s.hrdata[15:0] = s.rxm[s.rrd[AW-1:0]];
        next_s.rrd = s.rrd + (AW + 1)'(1);
      end else if (HADDR[7:0] >= smss_pkg::A_TGT_BASE && int'(roff[7:3]) < NT) begin
        next_s.hrdata = roff[2] ? s.cfgb[roff[3 +: TW]] : s.cfga[roff[3 +: TW]];
      end
    end
    toff = s.dp_addr - smss_pkg::A_TGT_BASE;
    if (s.dp_wr) begin
      if (s.dp_addr == smss_pkg::A_CONFIG) begin
        next_s.en = HWDATA[smss_pkg::CF_ENABLE] | next_s.en & ~s.en;
        next_s.slave = HWDATA[smss_pkg::CF_SLAVE];
        next_s.seq = HWDATA[smss_pkg::CF_SEQ] & ~HWDATA[smss_pkg::CF_SLAVE];
        next_s.commit = HWDATA[smss_pkg::CF_COMMIT];
        next_s.isd = HWDATA[smss_pkg::CF_ISD +: 8];
      end else if (s.dp_addr == smss_pkg::A_MAP) begin
        next_s.map = HWDATA[2*NT-1:0];
      end else if (s.dp_addr == smss_pkg::A_TXDATA && !s.seq && !tx_full) begin
        next_s.txm[s.twr[AW-1:0]] = HWDATA[15:0];
        next_s.twr = s.twr + (AW + 1)'(1);
      end else if (s.dp_addr == smss_pkg::A_FLUSH) begin
        if (HWDATA[0]) begin
          next_s.twr = '0;
          next_s.trd = '0;
          next_s.tbase = '0;
        end
        if (HWDATA[1]) begin
          next_s.rwr = '0;
          next_s.rrd = '0;
        end
      end else if (s.dp_addr == smss_pkg::A_CLEAR && HWDATA[0]) begin
        next_s.seq_ready = 1'b0;
      end else if (s.dp_addr >= smss_pkg::A_TGT_BASE && int'(toff[7:3]) < NT) begin
        if (toff[2]) begin
          next_s.cfgb[toff[3 +: TW]] = HWDATA;
        end else begin
          next_s.cfga[toff[3 +: TW]] = HWDATA;
        end
      end
    end
    // Completion beats a clear written in the same cycle
    if (fin) begin
      next_s.seq_ready = 1'b1;
    end
    // Replay start point follows the reader until sequential mode freezes it
    if (!next_s.seq) begin
      next_s.tbase = next_s.trd;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s <= '0;
      s.hready <= 1'b1;
      s.cs <= '1;
      s.txd_oe_n <= 1'b1;
      for (int i = 0; i < NT; i++) begin
        s.cfga[i] <= smss_pkg::CFGA_RST;
        s.cfgb[i] <= smss_pkg::CFGB_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hready;
  assign HRESP = s.hresp;
  assign SCK_OUT = s.sck;
  assign SCK_OE_N = s.sck_oe_n;
  assign CS_OUT_N = s.cs;
  assign TXD = s.txd;
  assign TXD_OE_N = s.txd_oe_n;
  assign SEQ_READY = s.seq_ready;

endmodule

/* File: test/smss_asserts.sv */
`timescale 1ns/100ps
module smss_asserts #(
  parameter int NT = 4
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  // Serial pins
  input wire logic SCK_OUT,
  input wire logic SCK_OE_N,
  input wire logic [NT-1:0] CS_OUT_N,
  input wire logic TXD,
  input wire logic TXD_OE_N,
  input wire logic SEQ_READY
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  logic clr_wr;
  logic rd_ph;
  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  // A clear write lands two edges after its address phase, so the flag may drop only then
  always_ff @(posedge SYS_CLK) begin
    clr_wr <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR[7:0] == smss_pkg::A_CLEAR;
    rd_ph <= HSEL && HTRANS[1] && HREADY && !HWRITE;
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reset_pins_a: assert property ($past(RESET) |-> !SCK_OUT && !SCK_OE_N &&
    &CS_OUT_N && !TXD && TXD_OE_N && !SEQ_READY) else $error("pins not idle after reset");
  idle_data_a: assert property (TXD_OE_N |-> !TXD) else $error("data high while off");
  start_drive_a: assert property ($fell(&CS_OUT_N) |-> !TXD_OE_N)
    else $error("select low without data pad");
  lead_guard_a: assert property ($fell(&CS_OUT_N) |-> $stable(SCK_OUT) [*3])
    else $error("clock moved inside lead guard");
  tail_guard_a: assert property ($rose(&CS_OUT_N) |-> $stable(SCK_OUT) &&
    SCK_OUT == $past(SCK_OUT, 2)) else $error("select rose right after a clock edge");
  one_select_a: assert property ($onehot0(~CS_OUT_N)) else $error("two selects low");
  slave_quiet_a: assert property (SCK_OE_N |-> &CS_OUT_N)
    else $error("select driven in slave mode");
  done_idle_a: assert property ($rose(SEQ_READY) |-> &CS_OUT_N && TXD_OE_N)
    else $error("sequence done with pins busy");
  flag_hold_a: assert property ($fell(SEQ_READY) |-> $past(clr_wr))
    else $error("ready flag dropped without clear");
  rdata_idle_a: assert property (!rd_ph |-> HRDATA == 32'h0) else $error("read data outside phase");
  cover property ($rose(SEQ_READY));
  cover property ($fell(&CS_OUT_N));
  cover property ($rose(SCK_OE_N));
endmodule
bind smss_top smss_asserts #(.NT(NT)) u_smss_asserts (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .CS_OUT_N(CS_OUT_N), .TXD(TXD),
  .TXD_OE_N(TXD_OE_N), .SEQ_READY(SEQ_READY));

/* File: test/smss_target.sv */
`timescale 1ns/100ps
module smss_target (
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Mode and reply, eight-bit words only
  input wire logic pol,
  input wire logic pha,
  input wire logic [15:0] reply,
  output logic [15:0] got
);
  int k = 0;
  initial miso = 1'b0;
  initial got = 16'h0000;
  always @(negedge cs_n) begin
    k = 0;
    got = 16'h0000;
    miso = pha ? ~miso : reply[7];
  end
  // A released line flips, so a stale bit never passes for a good one
  always @(posedge cs_n) miso = ~miso;
  always @(sck) begin
    if (!cs_n && sck == (pol ^ !pha)) begin
      got = {got[14:0], mosi};
    end else if (!cs_n) begin
      k = k + 1;
      // Words run back to back under one select, so the reply restarts every eight bits
      miso = reply[7 - (k - pha) % 8];
    end
  end
endmodule

/* File: test/tb_serial_master_slave_sequencer.sv */
`timescale 1ns/100ps
module tb_serial_master_slave_sequencer;
  logic SYS_CLK, HREADYOUT, HRESP, SCK_OUT, SCK_OE_N, TXD, TXD_OE_N, SEQ_READY, miso, RXD;
  logic RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, SCK_IN = 1'b0, CS_IN_N = 1'b1;
  logic slv = 1'b0, srx = 1'b0, pol = 1'b0, pha = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0] HTRANS = 2'b00;
  logic [3:0] CS_OUT_N, csq;
  logic [15:0] got;
  int n_mismatch = 0, n_compared = 0, cyc = 0, c0, v, t, dur[3], tgt[$];
  smss_top u_smss_top (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK_OUT(SCK_OUT),
    .SCK_OE_N(SCK_OE_N), .SCK_IN(SCK_IN), .CS_OUT_N(CS_OUT_N), .CS_IN_N(CS_IN_N), .TXD(TXD),
    .TXD_OE_N(TXD_OE_N), .RXD(RXD), .SEQ_READY(SEQ_READY));
  smss_target u_smss_target (.sck(SCK_OUT), .cs_n(&CS_OUT_N), .mosi(TXD), .miso(miso),
    .pol(pol), .pha(pha), .reply(16'h00c3), .got(got));
  assign RXD = slv ? srx : miso;
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Record the target of every new select, in order
  always @(posedge SYS_CLK) begin
    cyc++;
    csq <= CS_OUT_N;
    for (int i = 0; i < 4; i++) begin
      if (csq[i] && !CS_OUT_N[i]) tgt.push_back(i);
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrdy();
    int n;
    n = 0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1 && n < 50) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 50) chk(0, 1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wrdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wrdy();
    rd = HRDATA;
  endtask
  task automatic cfg(input int i, input logic [31:0] a, input logic [31:0] b);
    bus(1'b1, 8'(smss_pkg::A_TGT_BASE + 8 * i), a);
    bus(1'b1, 8'(smss_pkg::A_TGT_BASE + 8 * i + 4), b);
  endtask
  // Poll until nothing is queued and the link has gone quiet
  task automatic idle_wait();
    int n;
    n = 0;
    bus(1'b0, smss_pkg::A_STATUS, 0);
    while ((rd[2] !== 1'b0 || rd[12:8] !== 5'h0) && n < 3000) begin
      bus(1'b0, smss_pkg::A_STATUS, 0);
      n++;
    end
    if (n >= 3000) chk(0, 1);
  endtask
  task final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #900000;
    n_mismatch++;
    final_report();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    chk(SCK_OE_N, 0);
    chk({TXD, TXD_OE_N}, 2'b01);
    chk(CS_OUT_N, 4'hf);
    chk({HRESP, HREADYOUT}, 2'b01);
    bus(1'b0, smss_pkg::A_TGT_BASE, 0);
    chk(rd, smss_pkg::CFGA_RST);
    bus(1'b0, smss_pkg::A_TGT_BASE + 8'h04, 0);
    chk(rd, smss_pkg::CFGB_RST);
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd, 0);
    bus(1'b1, smss_pkg::A_MAP, 32'h4);
    bus(1'b1, smss_pkg::A_CONFIG, 32'h8);
    for (int m = 0; m < 4; m++) begin
      pol <= m[1];
      pha <= m[0];
      cfg(1, 32'h17, {14'h0, m[0], m[1], 8'h01, 8'h03});
      repeat (2) @(posedge SYS_CLK);
      chk(SCK_OUT, m[1]);
      bus(1'b1, smss_pkg::A_TXDATA, 32'h96 ^ m);
      bus(1'b1, smss_pkg::A_CONFIG, 32'h9);
      idle_wait();
      chk(got, 32'h96 ^ m);
      bus(1'b0, smss_pkg::A_RXDATA, 0);
      chk(rd, 32'hc3);
      chk({CS_OUT_N, TXD_OE_N}, 5'h1f);
      bus(1'b1, smss_pkg::A_CONFIG, 32'h8);
    end
    pol <= 1'b0;
    pha <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      cfg(1, {11'h0, p[0], 8'h02, 8'h00, 4'h7}, 32'h103);
      bus(1'b1, smss_pkg::A_TXDATA, 32'h11);
      bus(1'b1, smss_pkg::A_TXDATA, 32'h22);
      tgt.delete();
      bus(1'b1, smss_pkg::A_CONFIG, 32'h9);
      idle_wait();
      chk(tgt.size(), 1 + p);
      bus(1'b1, smss_pkg::A_FLUSH, 32'h2);
      bus(1'b1, smss_pkg::A_CONFIG, 32'h8);
    end
    cfg(0, 32'h27, 32'h103);
    cfg(1, 32'h17, 32'h103);
    cfg(3, 32'h17, 32'h103);
    for (int i = 0; i < 4; i++) bus(1'b1, smss_pkg::A_TXDATA, 32'h21 + 32'h10 * i);
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, smss_pkg::A_MAP, r == 2 ? 32'h45 : 32'h4d);
      bus(1'b1, smss_pkg::A_CONFIG, 32'h10c);
      tgt.delete();
      bus(1'b1, smss_pkg::A_CONFIG, 32'h10d);
      c0 = cyc;
      if (r == 1) bus(1'b1, smss_pkg::A_CONFIG, 32'h10c);
      t = 0;
      while (SEQ_READY !== 1'b1 && t < 5000) begin
        @(posedge SYS_CLK);
        t++;
      end
      dur[r] = cyc - c0;
      bus(1'b0, smss_pkg::A_CONFIG, 0);
      chk(rd[3:0], 4'h4);
      v = 0;
      foreach (tgt[i]) v = v * 16 + tgt[i];
      chk(v, r == 2 ? 32'h013 : 32'h03);
      chk(got, 32'h51);
      for (int i = 0; i < 4; i++) begin
        bus(1'b0, smss_pkg::A_RXDATA, 0);
        chk(rd, (i == 2 && r < 2) ? 32'h0 : 32'hc3);
      end
      bus(1'b1, smss_pkg::A_CLEAR, 32'h1);
      @(posedge SYS_CLK);
      chk(SEQ_READY, 0);
    end
    chk(dur[2], dur[0]);
    bus(1'b1, smss_pkg::A_CONFIG, 32'h0);
    bus(1'b1, smss_pkg::A_FLUSH, 32'h3);
    bus(1'b1, smss_pkg::A_CONFIG, 32'h3);
    slv <= 1'b1;
    CS_IN_N <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      srx <= 1'(8'h5a >> b);
      repeat (4) @(posedge SYS_CLK);
      SCK_IN <= 1'b1;
      chk(TXD, 0);
      repeat (4) @(posedge SYS_CLK);
      SCK_IN <= 1'b0;
    end
    repeat (4) @(posedge SYS_CLK);
    CS_IN_N <= 1'b1;
    srx <= ~srx;
    repeat (10) @(posedge SYS_CLK);
    bus(1'b0, smss_pkg::A_RXDATA, 0);
    chk(rd, 32'h5a);
    chk(SCK_OE_N, 1);
    final_report();
  end
endmodule
